// *** hdl/ife_defs.svh ***
// Register map, field positions and reset values of the flag/enable block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef IFE_DEFS_SVH
`define IFE_DEFS_SVH

// Register offsets on the plain register port
`define IFE_OFS_FLAGS_SIX 4'h0
`define IFE_OFS_FLAGS_SEVEN 4'h1
`define IFE_OFS_ENABLE_ZERO 4'h2
`define IFE_OFS_FLAG_EN 4'h3
`define IFE_OFS_STATUS 4'h4
`define IFE_OFS_MASK 4'h5

// Field positions
`define IFE_BIT_SELFTUNE 10
`define IFE_BIT_TEST_PORT 5

// Implemented bits of each register
`define IFE_IMPL_SIX 16'h0400
`define IFE_IMPL_SEVEN 16'h0020
`define IFE_IMPL_ENABLE 16'h7FFF
`define IFE_IMPL_EVT 16'h0003

// Reset values
`define IFE_RST_REG 16'h0000

`endif

// *** hdl/ife_irq_flag_enable_regs.sv ***
// Two flag status registers and the first enable register of the
// interrupt controller, with a small event status/mask pair.
// Assumes request inputs are synchronous to core_clk; register port
// strobes are one cycle wide and never both at once.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`include "ife_defs.svh"

////////////////////////////////////////////////////////////////////////////
module ife_irq_flag_enable_regs
  import ife_pkg::*;
#(
  parameter int NUM_SRC = 15
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Requests from sources
  input wire logic selftune_req,
  input wire logic test_port_req,
  input wire logic [NUM_SRC-1:0] src_flags,
  // Requests forwarded to the processor
  output logic [NUM_SRC-1:0] fwd_req,
  output logic selftune_fwd,
  output logic test_port_fwd,
  // Event interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_six = reg_wr & hit(reg_addr, `IFE_OFS_FLAGS_SIX);
  wire logic wr_seven = reg_wr & hit(reg_addr, `IFE_OFS_FLAGS_SEVEN);
  wire logic wr_enable = reg_wr & hit(reg_addr, `IFE_OFS_ENABLE_ZERO);
  wire logic wr_flag_en = reg_wr & hit(reg_addr, `IFE_OFS_FLAG_EN);
  wire logic wr_status = reg_wr & hit(reg_addr, `IFE_OFS_STATUS);
  wire logic wr_mask = reg_wr & hit(reg_addr, `IFE_OFS_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Flag bits
  logic selftune_irq_flag;
  logic test_port_irq_flag;
  logic [1:0] flag_en;
  logic [1:0] evt_mask;
  logic [1:0] evt_status;
  ife_word_t irq_enable_zero;

  // Hardware set beats a software write in the same cycle, so a request
  // arriving while software clears the flag still leaves it set.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      selftune_irq_flag <= 1'b0;
    end else if (selftune_req) begin
      selftune_irq_flag <= 1'b1;
    end else if (wr_six) begin
      selftune_irq_flag <= reg_wdata[`IFE_BIT_SELFTUNE];
    end
  end

  // Test-port flag, same policy
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_port_irq_flag <= 1'b0;
    end else if (test_port_req) begin
      test_port_irq_flag <= 1'b1;
    end else if (wr_seven) begin
      test_port_irq_flag <= reg_wdata[`IFE_BIT_TEST_PORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable register; bit 15 is not stored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_enable_zero <= `IFE_RST_REG;
    end else if (wr_enable) begin
      irq_enable_zero <= reg_wdata & `IFE_IMPL_ENABLE;
    end
  end

  // Enables for the two flags, and event mask
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag_en <= 2'h0;
      evt_mask <= 2'h0;
    end else begin
      if (wr_flag_en) begin
        flag_en <= reg_wdata[1:0];
      end
      if (wr_mask) begin
        evt_mask <= reg_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Forwarding gated by enables; bit positions follow the source enum
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_fwd
      assign fwd_req[g] = src_flags[g] & irq_enable_zero[g];
    end
  endgenerate

  // Position checks: A/D 13, serial tx 12, rx 11, SPI tx 10, SPI 9
  wire logic adc_irq_enable = irq_enable_zero[ife_src_adc];
  wire logic serial1_tx_irq_enable = irq_enable_zero[ife_src_u1tx];
  wire logic serial1_rx_irq_enable = irq_enable_zero[ife_src_u1rx];
  wire logic spi_one_txdone_irq_enable =
    irq_enable_zero[ife_src_spi1tx];
  wire logic spi_one_general_irq_enable =
    irq_enable_zero[ife_src_spi1];

  assign selftune_fwd = selftune_irq_flag & flag_en[0];
  assign test_port_fwd = test_port_irq_flag & flag_en[1];

  ////////////////////////////////////////////////////////////////////////
  // Sticky event status: rising edge of each forwarded flag request
  logic [1:0] fwd_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fwd_q <= 2'h0;
    end else begin
      fwd_q <= {test_port_fwd, selftune_fwd};
    end
  end

  wire logic [1:0] evt_rise = {test_port_fwd, selftune_fwd} & ~fwd_q;

  for (g = 0; g < 2; g++) begin : g_evt
    ife_sticky_bit u_sticky (
      .core_clk(core_clk),
      .reset(reset),
      .set_pulse(evt_rise[g]),
      .clear_one(wr_status & reg_wdata[g]),
      .flag(evt_status[g])
    );
  end

  // Level interrupt while any unmasked status bit stands
  assign irq = |(evt_status & evt_mask);

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unimplemented bits and unmapped addresses read zero
  ife_word_t rd_mux;
  wire ife_word_t six_word =
    16'({selftune_irq_flag} << `IFE_BIT_SELFTUNE);
  wire ife_word_t seven_word =
    16'({test_port_irq_flag} << `IFE_BIT_TEST_PORT);

  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `IFE_OFS_FLAGS_SIX: rd_mux = six_word & `IFE_IMPL_SIX;
      `IFE_OFS_FLAGS_SEVEN: rd_mux = seven_word & `IFE_IMPL_SEVEN;
      `IFE_OFS_ENABLE_ZERO: rd_mux = irq_enable_zero & `IFE_IMPL_ENABLE;
      `IFE_OFS_FLAG_EN: rd_mux = {14'h0000, flag_en};
      `IFE_OFS_STATUS: rd_mux = {14'h0000, evt_status};
      `IFE_OFS_MASK: rd_mux = {14'h0000, evt_mask};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// *** hdl/ife_pkg.sv ***
// Types shared by the flag/enable block.
// Assumes ife_defs.svh is on the include path.
`include "ife_defs.svh"
package ife_pkg;
  typedef logic [15:0] ife_word_t;
  typedef logic [3:0] ife_addr_t;
  // Source indices into the enable word
  typedef enum int {
    ife_src_ext0 = 0, ife_src_ic1 = 1, ife_src_oc1 = 2, ife_src_t1 = 3,
    ife_src_dma0 = 4, ife_src_ic2 = 5, ife_src_oc2 = 6, ife_src_t2 = 7,
    ife_src_t3 = 8, ife_src_spi1 = 9, ife_src_spi1tx = 10,
    ife_src_u1rx = 11, ife_src_u1tx = 12, ife_src_adc = 13,
    ife_src_dma1 = 14
  } ife_src_t;
endpackage

// *** hdl/ife_sticky_bit.sv ***
// One sticky status bit: set by an event pulse, cleared by write-one.
// Assumes set and clear come from logic on the same clock.
module ife_sticky_bit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic set_pulse,
  input wire logic clear_one,
  // State
  output logic flag
);
  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_one) begin
      flag <= 1'b0;
    end
  end
endmodule

// *** tb/ife_assertions.sv ***
// Port checker for the flag/enable block.
// Sees only the top module's ports; bound to it below.
module ife_chk #(
  parameter int NUM_SRC = 15
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Requests in and out
  input wire logic selftune_req,
  input wire logic test_port_req,
  input wire logic [NUM_SRC-1:0] src_flags,
  input wire logic [NUM_SRC-1:0] fwd_req,
  input wire logic selftune_fwd,
  input wire logic test_port_fwd,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // A lone read of one index; a write beside it would muddy the data
  sequence s_rd(a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  AST_IDLE_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  AST_SIX_UNUSED: assert property (s_rd(4'h0) |=> !(reg_rdata & 16'hFBFF))
    else $error("unused bit set in flags six");
  AST_SEVEN_UNUSED: assert property (s_rd(4'h1) |=> !(reg_rdata & 16'hFFDF))
    else $error("unused bit set in flags seven");
  AST_EN_TOP: assert property (s_rd(4'h2) |=> !reg_rdata[15])
    else $error("top enable bit reads one");
  AST_ST_SET: assert property (selftune_req ##1 !reg_wr ##1 s_rd(4'h0) |=> reg_rdata[10])
    else $error("self-tune flag not set by request");
  AST_TP_SET: assert property (test_port_req ##1 !reg_wr ##1 s_rd(4'h1) |=> reg_rdata[5])
    else $error("test-port flag not set by request");
  AST_FWD_SUBSET: assert property ((fwd_req & ~src_flags) == '0)
    else $error("request forwarded without its source");
  AST_ST_CAUSE: assert property ($rose(selftune_fwd) |-> $past(selftune_req || reg_wr))
    else $error("self-tune forward rose without cause");
endmodule

bind ife_irq_flag_enable_regs ife_chk #(.NUM_SRC(NUM_SRC)) i_chk (
  .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .selftune_req, .test_port_req, .src_flags, .fwd_req, .selftune_fwd,
  .test_port_fwd, .irq);

// *** tb/ife_src_model.sv ***
// Model of the peripheral request sources.
// Driven by bench task calls and, for src_flags, a direct bench assignment; outputs are synchronous to core_clk.
module ife_src_model (
  // Clock
  input wire logic core_clk,
  // Requests to the block
  output logic selftune_req,
  output logic test_port_req,
  output logic [14:0] src_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet at time zero so nothing leaks into reset
  initial begin
    selftune_req = 1'b0;
    test_port_req = 1'b0;
    src_flags = 15'h0000;
  end
  // One-cycle pulse: the shortest request a source may give
  task automatic fire(input logic st, input logic tp);
    @(posedge core_clk);
    selftune_req <= st;
    test_port_req <= tp;
    @(posedge core_clk);
    selftune_req <= 1'b0;
    test_port_req <= 1'b0;
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the flag/enable block.
// Assumes the checker binds itself to the block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ife_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  ife_addr_t reg_addr = 4'h0;
  ife_word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ife_word_t reg_rdata;
  logic selftune_req, test_port_req, selftune_fwd, test_port_fwd, irq;
  logic [14:0] src_flags, fwd_req;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  ife_src_model i_src (.core_clk, .selftune_req, .test_port_req, .src_flags);
  ife_irq_flag_enable_regs i_dut (.core_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .selftune_req, .test_port_req, .src_flags,
    .fwd_req, .selftune_fwd, .test_port_fwd, .irq);
  ////////////////////////////////////////
  // Compare, bus cycles and closing
  task automatic chk(string what, ife_word_t seen, ife_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(ife_addr_t a, ife_word_t d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so look just then
  task automatic rd(ife_addr_t a, ife_word_t exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Guard against a hang; the tests need about 120 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++)
      rd(a[3:0], 16'h0000);
    rd(4'hF, 16'h0000);
    $display("test reset done");
    wr(4'h0, 16'hFFFF);
    wr(4'h1, 16'hFFFF);
    wr(4'h2, 16'hFFFF);
    rd(4'h0, 16'h0400);
    rd(4'h1, 16'h0020);
    rd(4'h2, 16'h7FFF);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    rd(4'h0, 16'h0000);
    $display("test access done");
    i_src.src_flags <= 15'h7FFF;
    for (int i = 0; i < 15; i++) begin
      wr(4'h2, 16'h0001 << i);
      #1 chk("fwd_req", {1'b0, fwd_req}, 16'h0001 << i);
      rd(4'h2, 16'h0001 << i);
    end
    $display("test enables done");
    i_src.fire(1'b1, 1'b0);
    rd(4'h0, 16'h0400);
    rd(4'h1, 16'h0000);
    i_src.fire(1'b0, 1'b1);
    rd(4'h1, 16'h0020);
    wr(4'h3, 16'h0003);
    wr(4'h5, 16'h0001);
    #1 chk("irq", {15'h0000, irq}, 16'h0001);
    rd(4'h4, 16'h0003);
    wr(4'h4, 16'h0001);
    #1 chk("irq", {15'h0000, irq}, 16'h0000);
    rd(4'h4, 16'h0002);
    $display("test requests done");
    report_and_stop();
  end
endmodule
